//--- hdl/sdf_pkg.sv
// Constants and types shared by the sinc3 decimation filter
package sdf_pkg;
  // Decimation factor range and the value taken at reset
  localparam int SDF_N_MIN = 19;
  localparam int SDF_N_MAX = 8000;
  localparam int SDF_N_RESET = 312;
  localparam int SDF_N_W = 13;
  // Modulator rate divider: gain 1, speed 16 gives master / 32
  localparam int SDF_GAIN_DEFAULT = 1;
  localparam int SDF_SPEED_DEFAULT = 16;
  localparam int SDF_MOD_DIV = 2 * SDF_SPEED_DEFAULT * SDF_GAIN_DEFAULT;
  // Three cascaded stages; growth N^3 plus sign needs 41 bits
  localparam int SDF_STAGES = 3;
  localparam int SDF_ACC_W = 41;
  // Output word and its positive full scale
  localparam int SDF_OUT_W = 24;
  localparam int SDF_DIV_STEPS = SDF_OUT_W;
  localparam logic [SDF_OUT_W-1:0] SDF_POS_FULL = 24'h7FFFFF;
  // Cycles from a started division to the output strobe
  localparam int SDF_DIV_LATENCY = SDF_DIV_STEPS + 2;

  typedef enum logic [1:0] {
    SDF_IDLE = 2'h0,
    SDF_DIV = 2'h1,
    SDF_SEND = 2'h3
  } sdf_div_state_t;
endpackage

//--- hdl/sdf_stage_if.sv
// Carrier between the filter control and one integrator/comb stage
`timescale 1ns/1ps
`default_nettype none
interface sdf_stage_if #(
  parameter int W = sdf_pkg::SDF_ACC_W
) ();
  logic mod_en;
  logic dec_en;
  logic [W-1:0] int_in;
  logic [W-1:0] int_out;
  logic [W-1:0] comb_in;
  logic [W-1:0] comb_out;

  modport stage (
    input mod_en, dec_en, int_in, comb_in,
    output int_out, comb_out
  );
  modport ctrl (
    output mod_en, dec_en, int_in, comb_in,
    input int_out, comb_out
  );
endinterface
`default_nettype wire

//--- hdl/sdf_stage.sv
// One running-average stage: integrator at modulator rate, comb after
`timescale 1ns/1ps
`default_nettype none
module sdf_stage (
  input wire logic clk,
  input wire logic rst,
  sdf_stage_if.stage st
);
  localparam int W = $bits(st.int_in);

  typedef struct packed {
    logic [W-1:0] acc;
    logic [W-1:0] prev;
  } sdf_stage_state_t;

  sdf_stage_state_t s;
  sdf_stage_state_t next_s;

  // Wrap-around is intended; the comb difference undoes it
  always_comb begin
    next_s = s;
    if (st.mod_en) begin
      next_s.acc = s.acc + st.int_in;
    end
    if (st.dec_en) begin
      next_s.prev = st.comb_in;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign st.int_out = s.acc;
  // Comb left unregistered so the three differences settle in one cycle
  assign st.comb_out = st.comb_in - s.prev;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  acc_hold_a: assert property (!st.mod_en |=> $stable(s.acc))
    else $error("integrator moved without modulator enable");
endmodule
`default_nettype wire

//--- hdl/sdf_decim.sv
// Sinc3 decimation filter for a one-bit sigma-delta modulator stream
//
// Behaviour
// - Input is one bit, 1 means max level.
// - Feedback bit is delayed one modulator sample.
// - Output rate is modulator rate divided by N.
// - N programmable from 19 to 8000.
// - Three cascaded N-sample running averages.
// - Impulse response spans 3N, unity gain.
// - Each stage integrates, decimates, then differences.
// - Linear phase, delay of 3N/2 modulator samples.
// - Response zeros at multiples of output rate.
// - Only output-rate samples are presented outside.
// - Modulator rate is master clock over 32.
// - Output is 24-bit word, zero for zero input.
`timescale 1ns/1ps
`default_nettype none
module sdf_decim #(
  parameter int N_W = sdf_pkg::SDF_N_W,
  parameter int ACC_W = sdf_pkg::SDF_ACC_W,
  parameter int MOD_DIV = sdf_pkg::SDF_MOD_DIV
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic mod_bit_pin,
  input wire logic [N_W-1:0] decim_n,
  output logic [sdf_pkg::SDF_OUT_W-1:0] sample_word,
  output logic sample_valid,
  output logic mod_clk,
  output logic fb_bit
);
  localparam int OW = sdf_pkg::SDF_OUT_W;
  localparam int DIV_W = $clog2(MOD_DIV);
  localparam int NEED_W = 3 * $clog2(sdf_pkg::SDF_N_MAX + 1) + 2;
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(MOD_DIV - 1);
  localparam logic [DIV_W-1:0] DIV_HALF = DIV_W'(MOD_DIV / 2);
  localparam logic [N_W-1:0] N_MIN_V = N_W'(sdf_pkg::SDF_N_MIN);
  localparam logic [N_W-1:0] N_MAX_V = N_W'(sdf_pkg::SDF_N_MAX);
  localparam logic [N_W-1:0] N_RESET_V = N_W'(sdf_pkg::SDF_N_RESET);
  localparam logic [N_W-1:0] N_ONE = N_W'(1);
  localparam logic [1:0] FILL_FULL = 2'(sdf_pkg::SDF_STAGES);
  localparam logic [4:0] STEP_LAST = 5'(sdf_pkg::SDF_DIV_STEPS - 1);
  localparam logic [ACC_W-1:0] X_POS = ACC_W'(1);
  localparam logic [ACC_W-1:0] X_NEG = '1;
  localparam int MOD_GAP = MOD_DIV;
  localparam int DIV_LAT = sdf_pkg::SDF_DIV_LATENCY;

  // Refuse sizes the arithmetic cannot serve
  if (ACC_W < NEED_W) begin : g_acc_chk
    $error("ACC_W too small for N^3 growth");
  end
  if (MOD_DIV < 2 || (MOD_DIV % 2) != 0) begin : g_div_chk
    $error("MOD_DIV must be even and at least 2");
  end
  if (N_W < $clog2(sdf_pkg::SDF_N_MAX + 1)) begin : g_nw_chk
    $error("N_W too small for the largest decimation factor");
  end

  typedef struct packed {
    logic [2:0] sync;
    logic bit_ok;
    logic [DIV_W-1:0] div_cnt;
    logic mod_en;
    logic mod_clk;
    logic fb;
    logic [N_W-1:0] n_cur;
    logic [N_W-1:0] dec_cnt;
    logic dec_en;
    logic [1:0] fill;
    logic [ACC_W-1:0] dvsr;
    logic [ACC_W-1:0] rem;
    logic [OW-1:0] quo;
    logic neg;
    logic [4:0] step;
    sdf_pkg::sdf_div_state_t st;
    logic [OW-1:0] word;
    logic valid;
  } sdf_state_t;

  sdf_state_t s;
  sdf_state_t next_s;

  logic [ACC_W-1:0] x_in;
  logic [ACC_W-1:0] filt;
  logic [ACC_W-1:0] n_cube;

  // Stage chain: integrators 0->1->2, combs fed from the last integrator
  sdf_stage_if #(.W(ACC_W)) stg [sdf_pkg::SDF_STAGES] ();

  // A 1 pulls the average toward full positive scale
  assign x_in = s.bit_ok ? X_POS : X_NEG;

  for (genvar g = 0; g < sdf_pkg::SDF_STAGES; g++) begin : g_stage
    assign stg[g].mod_en = s.mod_en;
    assign stg[g].dec_en = s.dec_en;
    if (g == 0) begin : g_first
      assign stg[g].int_in = x_in;
      assign stg[g].comb_in = stg[sdf_pkg::SDF_STAGES-1].int_out;
    end else begin : g_rest
      assign stg[g].int_in = stg[g-1].int_out;
      assign stg[g].comb_in = stg[g-1].comb_out;
    end
    sdf_stage u_stage (
      .clk(clk),
      .rst(rst),
      .st(stg[g])
    );
  end

  // Sum of 3N-long impulse response; divided by N^3 below for unity gain
  // Symmetric taps give the 3N/2 sample delay without extra logic
  assign filt = stg[sdf_pkg::SDF_STAGES-1].comb_out;
  assign n_cube = ACC_W'(s.n_cur) * ACC_W'(s.n_cur) * ACC_W'(s.n_cur);

  always_comb begin
    logic [ACC_W-1:0] trial;
    logic qb;
    logic [OW-1:0] sat;
    trial = '0;
    qb = 1'b0;
    sat = '0;
    next_s = s;
    next_s.mod_en = 1'b0;
    next_s.dec_en = 1'b0;
    next_s.valid = 1'b0;

    // Pin synchroniser; the level is taken once two later stages agree
    next_s.sync = {s.sync[1:0], mod_bit_pin};
    if (s.sync[1] == s.sync[2]) begin
      next_s.bit_ok = s.sync[2];
    end

    // Modulator sample enable from the master clock
    if (s.div_cnt == DIV_LAST) begin
      next_s.div_cnt = '0;
      next_s.mod_en = 1'b1;
    end else begin
      next_s.div_cnt = s.div_cnt + 1'b1;
    end
    next_s.mod_clk = (next_s.div_cnt < DIV_HALF);

    if (s.mod_en) begin
      // Bit decided in this sample returns to the modulator next sample
      next_s.fb = s.bit_ok;
      if (s.dec_cnt == s.n_cur - N_ONE) begin
        next_s.dec_cnt = '0;
        next_s.dec_en = 1'b1;
      end else begin
        next_s.dec_cnt = s.dec_cnt + N_ONE;
      end
    end

    if (s.dec_en) begin
      // First words after start or an N change are transients; drop them
      if (s.fill == FILL_FULL && s.st == sdf_pkg::SDF_IDLE) begin
        next_s.neg = filt[ACC_W-1];
        next_s.rem = filt[ACC_W-1] ? -filt : filt;
        next_s.dvsr = n_cube;
        next_s.quo = '0;
        next_s.step = '0;
        next_s.st = sdf_pkg::SDF_DIV;
      end
      // New N applies only at a frame edge; out-of-range values ignored
      if (decim_n >= N_MIN_V && decim_n <= N_MAX_V &&
          decim_n != s.n_cur) begin
        next_s.n_cur = decim_n;
        next_s.fill = '0;
      end else if (s.fill != FILL_FULL) begin
        next_s.fill = s.fill + 2'h1;
      end
    end

    // Restoring division: quotient is |y| * 2^23 / N^3
    unique case (s.st)
      sdf_pkg::SDF_IDLE: begin
      end
      sdf_pkg::SDF_DIV: begin
        trial = (s.step == '0) ? s.rem : {s.rem[ACC_W-2:0], 1'b0};
        if (trial >= s.dvsr) begin
          next_s.rem = trial - s.dvsr;
          qb = 1'b1;
        end else begin
          next_s.rem = trial;
        end
        next_s.quo = {s.quo[OW-2:0], qb};
        if (s.step == STEP_LAST) begin
          next_s.st = sdf_pkg::SDF_SEND;
        end else begin
          next_s.step = s.step + 5'h1;
        end
      end
      sdf_pkg::SDF_SEND: begin
        // Full scale 2^23 does not fit; clip symmetrically
        sat = s.quo[OW-1] ? sdf_pkg::SDF_POS_FULL : s.quo;
        next_s.word = s.neg ? -sat : sat;
        next_s.valid = 1'b1;
        next_s.st = sdf_pkg::SDF_IDLE;
      end
      default: begin
        next_s.st = sdf_pkg::SDF_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s <= '0;
      s.n_cur <= N_RESET_V;
    end else begin
      s <= next_s;
    end
  end

  assign sample_word = s.word;
  assign sample_valid = s.valid;
  assign mod_clk = s.mod_clk;
  assign fb_bit = s.fb;

  // Helper: modulator samples seen in the current output frame
  logic [N_W-1:0] chk_cnt;
  always_ff @(posedge clk) begin
    if (rst) begin
      chk_cnt <= '0;
    end else if (s.dec_en) begin
      chk_cnt <= '0;
    end else if (s.mod_en) begin
      chk_cnt <= chk_cnt + N_ONE;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  mod_period_a: assert property (s.mod_en |-> ##MOD_GAP s.mod_en)
    else $error("modulator enable period wrong");

  mod_gap_a: assert property (s.mod_en |=> !s.mod_en [*8])
    else $error("modulator enable repeated too soon");

  fb_delay_a: assert property (
    s.mod_en |=> (fb_bit == $past(s.bit_ok)) ##1 $stable(fb_bit) [*8]
  )
    else $error("feedback bit not one sample late");

  n_range_a: assert property (
    s.n_cur >= N_MIN_V && s.n_cur <= N_MAX_V
  )
    else $error("decimation factor out of range");

  // Factor in force until the strobe; a new one starts the next frame
  frame_len_a: assert property (s.dec_en |-> chk_cnt == s.n_cur)
    else $error("output frame not N modulator samples");

  dec_after_mod_a: assert property (s.dec_en |-> $past(s.mod_en))
    else $error("decimation strobe not after a sample");

  strobe_one_a: assert property (sample_valid |=> !sample_valid)
    else $error("output strobe longer than one cycle");

  word_hold_a: assert property (
    $changed(sample_word) |-> sample_valid
  )
    else $error("output word changed without strobe");

  div_time_a: assert property (
    s.st == sdf_pkg::SDF_IDLE && s.dec_en && s.fill == FILL_FULL
    |-> ##DIV_LAT sample_valid
  )
    else $error("output word late after frame end");

  word_sign_a: assert property (
    sample_valid && sample_word != '0 |-> sample_word[OW-1] == s.neg
  )
    else $error("output word sign wrong");

  // A pin level is taken only once flops two and three agree
  sync_agree_a: assert property (
    $changed(s.bit_ok) |-> $past(s.sync[1]) == $past(s.sync[2])
  )
    else $error("input bit taken before the synchroniser settled");

  n_adopt_a: assert property (
    s.dec_en && decim_n >= N_MIN_V && decim_n <= N_MAX_V &&
    decim_n != s.n_cur |=> s.n_cur == $past(decim_n) && s.fill == '0
  )
    else $error("valid decimation factor not adopted at frame end");

  n_keep_a: assert property (!s.dec_en |=> $stable(s.n_cur))
    else $error("decimation factor changed inside a frame");

  // Transient frames after a factor change must stay invisible
  fill_quiet_a: assert property (
    s.dec_en && s.fill != FILL_FULL |-> ##DIV_LAT !sample_valid
  )
    else $error("output word sent while the pipeline fills");

  pos_word_c: cover property (sample_valid && !sample_word[OW-1]);
  neg_word_c: cover property (sample_valid && sample_word[OW-1]);
  n_change_c: cover property (s.dec_en && s.fill == FILL_FULL ##1
    s.fill == '0);
  full_scale_c: cover property (
    sample_valid && sample_word == sdf_pkg::SDF_POS_FULL
  );
  bad_n_c: cover property (
    s.dec_en && (decim_n < N_MIN_V || decim_n > N_MAX_V)
  );
endmodule
`default_nettype wire

//--- testbench/sdf_mod_model.sv
// Behavioural one-bit modulator feeding the filter's bit pin
`timescale 1ns/1ps
`default_nettype none
module sdf_mod_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic mod_clk,
  input wire logic [1:0] mode,
  output logic bit_out,
  output logic sent
);
  logic mod_clk_d;

  always @(posedge clk) begin
    mod_clk_d <= mod_clk;
    if (rst) begin
      bit_out <= 1'b0;
      sent <= 1'b0;
    end else begin
      // Bit moves on the falling edge so it is settled at the rising one
      if (mod_clk_d && !mod_clk) begin
        case (mode)
          2'h0: bit_out <= 1'b0;
          2'h1: bit_out <= 1'b1;
          default: bit_out <= ~bit_out;
        endcase
      end
      // Bit the filter must echo on its feedback line
      if (!mod_clk_d && mod_clk) begin
        sent <= bit_out;
      end
    end
  end
endmodule
`default_nettype wire

//--- testbench/sinc3_decimation_filter_tb.sv
// Self-checking bench for the sinc3 decimation filter
`timescale 1ns/1ps
`default_nettype none
module sinc3_decimation_filter_tb;
  localparam int TIME_LIMIT = 80000;
  localparam int MOD_RATIO = 32;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [12:0] decim_n = 13'h0013;
  logic [1:0] mode = 2'h1;
  logic mod_bit_pin;
  logic mod_clk;
  logic fb_bit;
  logic sent;
  logic sample_valid;
  logic [sdf_pkg::SDF_OUT_W-1:0] sample_word;
  logic chk_fb = 1'b0;
  int err_count = 0;
  int n_compared = 0;
  int cycles = 0;
  int n_cur;
  int bad_n [3];

  always #4 clk = ~clk;

  sdf_decim DUT (
    .clk(clk),
    .rst(rst),
    .mod_bit_pin(mod_bit_pin),
    .decim_n(decim_n),
    .sample_word(sample_word),
    .sample_valid(sample_valid),
    .mod_clk(mod_clk),
    .fb_bit(fb_bit)
  );

  sdf_mod_model u_mod (
    .clk(clk),
    .rst(rst),
    .mod_clk(mod_clk),
    .mode(mode),
    .bit_out(mod_bit_pin),
    .sent(sent)
  );

  task automatic stop_test();
    $display("Compared %0d, mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic cmp_word(input logic [23:0] got, input logic [23:0] exp,
                          input string msg);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH %0t %s: %h vs %h", $time, msg, got, exp);
    end
  endtask

  task automatic cmp_bit(input logic got, input logic exp, input string msg);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH %0t %s: %b vs %b", $time, msg, got, exp);
    end
  endtask

  task automatic cmp_num(input int got, input int exp, input string msg);
    n_compared++;
    if (got != exp) begin
      err_count++;
      $display("MISMATCH %0t %s: %0d vs %0d", $time, msg, got, exp);
    end
  endtask

  // Ideal word for a steady or alternating stream, scaled and clipped
  function automatic logic [23:0] exp_word(input int m, input int n);
    longint cube;
    longint y;
    longint mag;
    cube = longint'(n) * n * n;
    y = (m == 1) ? cube : ((m == 0) ? -cube : 0);
    mag = ((y < 0 ? -y : y) << 23) / cube;
    if (mag > 64'h7FFFFF) begin
      mag = 64'h7FFFFF;
    end
    return (y < 0) ? 24'(-mag) : 24'(mag);
  endfunction

  always @(posedge clk) begin
    cycles++;
    if (cycles == TIME_LIMIT) begin
      err_count++;
      stop_test();
    end
  end

  always @(negedge mod_clk) begin
    if (chk_fb) begin
      cmp_bit(fb_bit, sent, "feedback bit");
    end
  end

  task automatic check_mod_clk();
    int hi;
    int lo;
    hi = 0;
    lo = 0;
    while (mod_clk !== 1'b1) begin
      @(posedge clk);
      #1;
    end
    // First high phase after reset is short; measure a whole period
    while (mod_clk === 1'b1) begin
      @(posedge clk);
      #1;
    end
    while (mod_clk !== 1'b1 && lo < 64) begin
      @(posedge clk);
      #1;
      lo++;
    end
    while (mod_clk === 1'b1 && hi < 64) begin
      @(posedge clk);
      #1;
      hi++;
    end
    cmp_num(hi, MOD_RATIO / 2, "modulator clock high");
    cmp_num(lo, MOD_RATIO / 2, "modulator clock low");
    $display("Test done: modulator clock");
  endtask

  // Four words: the first ones may still hold the previous stream
  task automatic run_case(input logic [1:0] m, input int n_set,
                          input int n_exp, input string name);
    int gap;
    mode = m;
    decim_n = 13'(n_set);
    for (int i = 0; i < 4; i++) begin
      gap = 1;
      while (sample_valid !== 1'b1 && gap < 20000) begin
        @(posedge clk);
        #1;
        gap++;
      end
      @(posedge clk);
      #1;
      cmp_bit(sample_valid, 1'b0, "strobe width");
    end
    cmp_num(gap, n_exp * MOD_RATIO, "word spacing");
    cmp_word(sample_word, exp_word(m, n_exp), "word value");
    $display("Test done: %s N=%0d", name, n_set);
  endtask

  initial begin
    void'($urandom(49985));
    repeat (5) @(posedge clk);
    #1;
    cmp_word(sample_word, 24'h000000, "word in reset");
    cmp_bit(sample_valid, 1'b0, "strobe in reset");
    rst = 1'b0;
    check_mod_clk();
    chk_fb = 1'b1;
    run_case(2'h1, 19, 19, "all high");
    n_cur = 19 + $urandom_range(21);
    run_case(2'h0, n_cur, n_cur, "all low");
    n_cur = 20 + 2 * $urandom_range(10);
    run_case(2'h2, n_cur, n_cur, "alternating");
    // Out-of-range requests must leave the factor alone
    bad_n[0] = 18;
    bad_n[1] = 8001;
    bad_n[2] = 8001 + $urandom_range(190);
    foreach (bad_n[i]) begin
      run_case(2'h2, bad_n[i], n_cur, "rejected factor");
    end
    stop_test();
  end
endmodule
`default_nettype wire
